// File: hw/rsr_regs.vh
// constants for the recirculating shift register
`ifndef RSR_REGS_VH
`define RSR_REGS_VH
`define RSR_LOOP_LEN      1024
`define RSR_FIFO_DEPTH    8
`define RSR_CLK_HZ        50000000
// host shift clock limits, in hz (0.0005 mhz to 3 mhz)
`define RSR_SHIFT_MIN_HZ  500
`define RSR_SHIFT_MAX_HZ  3000000
// longest idle gap between shift clocks before contents are lost
`define RSR_STALE_CYC     (`RSR_CLK_HZ / `RSR_SHIFT_MIN_HZ)
`endif

// File: hw/rsr_fifo.v
// fifo buffer: its module is defined in rsr_top.v with the rest of the logic

// File: hw/rsr_top.v
// 1024-stage recirculating serial store with write/read gating
`timescale 1ns/100ps
`include "rsr_regs.vh"
// What this block does
// RL1 - one serial bit stream in a 1024-stage loop, 1024 shifts end to end
// RL2 - write low, read low: recirculate, output held at zero
// RL3 - write low, read high: recirculate, output shows leaving bit
// RL4 - write high, read low: load data-in, output held at zero
// RL5 - write high, read high: load data-in, output shows leaving bit
// RL6 - host keeps shift clock between 0.0005 and 3 mhz or data is lost
// RL7 - one stage per shift clock; controls stable across each shift clock
module rsr_top #(
  parameter LOOP_LEN  = `RSR_LOOP_LEN,
  parameter STALE_CYC = `RSR_STALE_CYC
) (
  // clock and reset
  input  wire clock,
  input  wire sys_rst,
  // host pins, asynchronous to clock
  input  wire shift_clk,
  input  wire data_in,
  input  wire write_en,
  input  wire read_en,
  // serial output, at most one entry per shift clock, through the fifo
  output reg  data_out,
  output reg  data_out_valid,
  input  wire data_out_ready,
  // status
  output reg  contents_stale
);
  // pointer width follows the loop length
  localparam          AW        = (LOOP_LEN > 1) ? $clog2(LOOP_LEN) : 1;
  localparam [31:0]   LAST_FULL = LOOP_LEN - 1;
  localparam [AW-1:0] LAST_IDX  = LAST_FULL[AW-1:0];
  // positions of the host pins in the synchroniser bus
  localparam          NPIN      = 4;
  localparam          PIN_SCLK  = 0;
  localparam          PIN_DIN   = 1;
  localparam          PIN_WR    = 2;
  localparam          PIN_RD    = 3;
  // {write, read} combinations
  localparam [1:0]    MODE_KEEP_HIDE = 2'h0;
  localparam [1:0]    MODE_KEEP_SHOW = 2'h1;
  localparam [1:0]    MODE_LOAD_HIDE = 2'h2;
  localparam [1:0]    MODE_LOAD_SHOW = 2'h3;

  wire [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] pin_agree;
  wire [NPIN-1:0] pin_third;
  wire [NPIN-1:0] pin_filt;

  assign pin_raw = {read_en, write_en, data_in, shift_clk};

  // three flops per pin; a level counts once the second and third agree,
  // so a single sampled glitch cannot cause a shift
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_sync
      reg [2:0] sync_r;
      reg       filt_r;
      always @(posedge clock) begin
        sync_r <= {sync_r[1:0], pin_raw[g]};
        if (sys_rst) begin
          filt_r <= 1'b0;
        end else if (sync_r[1] == sync_r[2]) begin
          filt_r <= sync_r[2];
        end
      end
      assign pin_agree[g] = (sync_r[1] == sync_r[2]);
      assign pin_third[g] = sync_r[2];
      assign pin_filt[g]  = filt_r;
    end
  endgenerate

  wire din_f = pin_filt[PIN_DIN];
  wire wr_f  = pin_filt[PIN_WR];
  wire rd_f  = pin_filt[PIN_RD];

  // one shift per rising edge of the host clock
  wire shift_now = pin_agree[PIN_SCLK] & pin_third[PIN_SCLK]
                 & ~pin_filt[PIN_SCLK]; // RL7

  // storage loop: circular buffer, no reset on the array (dynamic store)
  reg [0:0]    loop_mem [0:LOOP_LEN-1];
  reg [AW-1:0] ptr_r;
  wire         leaving = loop_mem[ptr_r];
  reg          enter;
  reg          obit;

  // write picks the loop input, read gates the output; a gated bit still
  // goes to the fifo as zero so every shift yields one entry unless the fifo is full
  always @* begin
    enter = leaving;
    obit  = 1'b0;
    case ({wr_f, rd_f})
      MODE_KEEP_HIDE: begin
        enter = leaving; // RL2
        obit  = 1'b0;
      end
      MODE_KEEP_SHOW: begin
        enter = leaving; // RL3
        obit  = leaving;
      end
      MODE_LOAD_HIDE: begin
        enter = din_f; // RL4
        obit  = 1'b0;
      end
      MODE_LOAD_SHOW: begin
        enter = din_f; // RL5
        obit  = leaving;
      end
      default: begin
        enter = leaving;
        obit  = 1'b0;
      end
    endcase
  end

  always @(posedge clock) begin
    if (shift_now) begin
      loop_mem[ptr_r] <= enter; // RL1
    end
    if (sys_rst) begin
      ptr_r <= {AW{1'b0}};
    end else if (shift_now) begin
      ptr_r <= (ptr_r == LAST_IDX) ? {AW{1'b0}} : ptr_r + 1'b1; // RL1
    end
  end

  // fifo decouples shift rate from the consumer; a full fifo drops bits
  // because the host clock cannot be stalled
  wire f_ready;
  wire f_valid;
  wire f_data;
  rsr_fifo #(
    .WIDTH (1),
    .DEPTH (`RSR_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (shift_now),
    .in_ready  (f_ready),
    .in_data   (obit),
    .out_valid (f_valid),
    .out_ready (~data_out_valid | data_out_ready),
    .out_data  (f_data)
  );

  // output stage register
  always @(posedge clock) begin
    if (sys_rst) begin
      data_out       <= 1'b0;
      data_out_valid <= 1'b0;
    end else if (~data_out_valid | data_out_ready) begin
      data_out       <= f_valid & f_data;
      data_out_valid <= f_valid;
    end
  end

  // watchdog: host stopped clocking too long, contents unreliable
  reg [31:0] idle_r;
  always @(posedge clock) begin
    if (sys_rst) begin
      idle_r         <= 32'h0000_0000;
      contents_stale <= 1'b0;
    end else if (shift_now) begin
      idle_r         <= 32'h0000_0000;
    end else if (idle_r < STALE_CYC) begin
      idle_r         <= idle_r + 32'h0000_0001;
    end else begin
      contents_stale <= 1'b1; // RL6
    end
  end
endmodule

// small synchronous fifo with valid/ready on both sides
module rsr_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clock,
  input  wire             sys_rst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_r;
  reg [AW-1:0]    rd_r;
  reg [AW:0]      cnt_r;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem[rd_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clock) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
    if (sys_rst) begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// File: verification/rsr_host.sv
// host model driving shift clock, data and controls
`timescale 1ns/100ps
module rsr_host (
  // system clock
  input  wire clock,
  // host pins
  output reg  shift_clk,
  output reg  data_in,
  output reg  write_en,
  output reg  read_en
);
  initial {shift_clk, data_in, write_en, read_en} = 4'h0;
  // 18 clocks a shift keeps the rate under 3 mhz
  task shift(input w, input r, input d);
    {write_en, read_en, data_in} <= {w, r, d};
    repeat (6) @(posedge clock);
    shift_clk <= 1'h1;
    repeat (6) @(posedge clock);
    shift_clk <= 1'h0;
    repeat (6) @(posedge clock);
  endtask
endmodule

// File: verification/rsr_top_asserts.sv
// port assertions for the serial store
`timescale 1ns/100ps
module rsr_checker #(parameter STALE_CYC = 50) (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // host pins
  input wire shift_clk,
  input wire read_en,
  // output side
  input wire data_out,
  input wire data_out_valid,
  input wire data_out_ready,
  input wire contents_stale
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  int idle;
  always @(posedge clock)
    idle <= (sys_rst || shift_clk) ? 0 : idle + 1;
  quiet_zero_a:
    assert property ($rose(data_out_valid) && !read_en |-> !data_out)
    else $error("nonzero output");
  shift_answer_a:
    assert property ($rose(shift_clk) && data_out_ready && !data_out_valid
      |-> ##[3:8] data_out_valid) else $error("no output");
  hold_out_a:
    assert property (data_out_valid && !data_out_ready
      |=> data_out_valid && $stable(data_out)) else $error("output lost");
  stale_set_a:
    assert property (idle > STALE_CYC + 8 |-> contents_stale)
    else $error("stale missing");
  stale_keep_a:
    assert property (contents_stale |=> contents_stale)
    else $error("stale cleared");
  reset_clear_a:
    assert property ($past(sys_rst) |-> !data_out_valid && !contents_stale)
    else $error("set after reset");
  cover property ($rose(data_out_valid) && read_en && data_out);
  cover property (data_out_valid && !data_out_ready);
  cover property ($rose(contents_stale));
endmodule
bind rsr_top rsr_checker #(.STALE_CYC(STALE_CYC)) rsr_checker_inst (.*);

// File: verification/testbench.sv
// testbench for the recirculating serial store
`timescale 1ns/100ps
module testbench;
  localparam LEN = 16;
  logic clock = 1'h0, sys_rst = 1'h1, data_out_ready = 1'h1;
  wire  shift_clk, data_in, write_en, read_en;
  wire  data_out, data_out_valid, contents_stale;
  int   miscompares = 0, total_checks = 0, cyc = 0;
  logic q[$];
  initial forever #10 clock = ~clock;
  rsr_host rsr_host_inst (.*);
  rsr_top #(.LOOP_LEN(LEN), .STALE_CYC(50)) rsr_top_inst (.*);
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (data_out_valid === 1'h1 && data_out_ready) q.push_back(data_out);
    if (cyc == 5000) begin
      miscompares++;
      results();
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one trip round the loop, lsb first
  task pass(input w, input r, input [15:0] d, input [15:0] exp);
    logic [15:0] got;
    q = {};
    for (int i = 0; i < LEN; i++) rsr_host_inst.shift(w, r, d[i]);
    repeat (6) @(posedge clock);
    got = 16'h0;
    for (int i = 0; i < LEN && i < q.size(); i++) got[i] = q[i];
    check(16'(q.size()), 16'(LEN));
    check(got, exp);
  endtask
  task t_write;
    pass(1, 0, 16'ha5c3, 16'h0);
  endtask
  task t_read;
    pass(0, 1, 16'h0, 16'ha5c3);
  endtask
  task t_quiet;
    pass(0, 0, 16'h0, 16'h0);
    pass(0, 1, 16'h0, 16'ha5c3);
  endtask
  task t_both;
    pass(1, 1, 16'h3c96, 16'ha5c3);
    pass(0, 1, 16'h0, 16'h3c96);
  endtask
  // fifo plus output stage hold nine bits, later ones drop
  task t_stall;
    data_out_ready <= 1'h0;
    q = {};
    repeat (12) rsr_host_inst.shift(0, 1, 0);
    data_out_ready <= 1'h1;
    repeat (12) @(posedge clock);
    check(16'(q.size()), 16'h0009);
  endtask
  task t_stale;
    repeat (60) @(posedge clock);
    check({15'h0, contents_stale}, 16'h0001);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'h0;
    repeat (4) @(posedge clock);
    t_write;
    t_read;
    t_quiet;
    t_both;
    t_stall;
    t_stale;
    results();
  end
endmodule
